/* core/pml_ctrl.sv */
// processor-bus memory controller: beat timing, ecc, interleave, boot map
`timescale 1ns/1ps
module pml_ctrl
(
   input  wire logic                      mclk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      transfer_start_strobe_n_i,
   input  wire logic [pml_pkg::ADDR_W-1:0] addr_i,
   input  wire logic                      write_i,
   input  wire logic                      burst_i,
   input  wire logic                      one_byte_i,
   input  wire logic                      edo_mode_i,
   input  wire logic                      boot_bank_strap_i,
   input  wire logic [71:0]               rd_word_i,
   output logic                           address_acknowledge_n_o,
   output logic                           beat_o,
   output logic [63:0]                    rd_data_o,
   output logic                           ecc_single_o,
   output logic                           ecc_double_o,
   output logic                           block_b_o,
   output logic                           flash_b_o,
   output logic                           busy_o
);
   import pml_pkg::*;

   // pin inputs cross through three flops; second and third must agree
   logic [2:0] strap_sy;
   logic [2:0] edo_sy;
   logic       strap_q;       // filtered strap
   logic       edo_q;         // filtered timing mode
   logic       next_strap_q;
   logic       next_edo_q;

   always_comb
   begin
      // change counts only once the late pair agrees
      next_strap_q = (strap_sy[1] == strap_sy[2]) ? strap_sy[2] : strap_q;
      next_edo_q   = (edo_sy[1] == edo_sy[2]) ? edo_sy[2] : edo_q;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         strap_sy <= {3{STRAP_RST}};
         edo_sy   <= 3'h0;
         strap_q  <= STRAP_RST;
         edo_q    <= 1'b0;
      end
      else
      begin
         strap_sy <= {strap_sy[1:0], boot_bank_strap_i};
         edo_sy   <= {edo_sy[1:0], edo_mode_i};
         strap_q  <= next_strap_q;
         edo_q    <= next_edo_q;
      end
   end

   // ecc syndrome over the 72-bit span, hamming plus overall parity
   function automatic logic [7:0] pml_syn(input logic [71:0] w);
      logic [7:0] s;
      s = 8'h00;
      for (int i = 1; i < 72; i++)
         for (int b = 0; b < 7; b++)
            if (i[b])
               s[b] = s[b] ^ w[i];
      s[7] = ^w;
      return s;
   endfunction

   // first-beat count for the access kind, idle or back-to-back
   function automatic logic [7:0] pml_first(input logic edo,
      input pml_kind_t k, input pml_kind_t prev, input logic hit,
      input logic mis);
      logic [7:0] f;
      logic       b2b;
      b2b = (prev == k);
      f   = 8'h01;
      case (k)
         PML_BRD:
            if (!b2b)
               f = edo ? ED_BRD_IDLE : FP_BRD_IDLE;
            else if (mis)
               f = edo ? (hit ? ED_BRDM_HIT : ED_BRDM_MISS)
                       : (hit ? FP_BRDM_HIT : FP_BRDM_MISS);
            else
               f = edo ? (hit ? ED_BRD_HIT : ED_BRD_MISS)
                       : (hit ? FP_BRD_HIT : FP_BRD_MISS);
         PML_BWR:
            if (!b2b)
               f = edo ? ED_BWR_IDLE : FP_BWR_IDLE;
            else
               f = edo ? (hit ? ED_BWR_HIT : ED_BWR_MISS)
                       : (hit ? FP_BWR_HIT : FP_BWR_MISS);
         PML_SRD:
            if (!b2b)
               f = edo ? ED_SRD_IDLE : FP_SRD_IDLE;
            else
               f = edo ? (hit ? ED_SRD_HIT : ED_SRD_MISS)
                       : (hit ? FP_SRD_HIT : FP_SRD_MISS);
         PML_SWR:
            if (!b2b)
               f = edo ? ED_SWR_IDLE : FP_SWR_IDLE;
            else
               f = edo ? (hit ? ED_SWR_HIT : ED_SWR_MISS)
                       : (hit ? FP_SWR_HIT : FP_SWR_MISS);
         default:
            f = 8'h01;
      endcase
      return f;
   endfunction

   // gap before beat n (1..3) of a dram burst read
   function automatic logic [7:0] pml_gap(input logic edo,
      input logic mis, input logic [1:0] n);
      logic [7:0] g;
      g = 8'h01;
      if (!edo && !mis && n == 2'd2)
         g = 8'h02;
      else if (mis && n == 2'd1)
         g = edo ? 8'h02 : 8'h03;
      return g;
   endfunction

   typedef enum logic [1:0] {
      PML_S_IDLE,
      PML_S_WAIT
   } pml_state_t;

   pml_state_t                state, next_state;
   pml_kind_t                 kind, next_kind;    // current access
   pml_kind_t                 prev, next_prev;    // last dram kind
   pml_tgt_t                  tgt, next_tgt;
   logic [7:0]                cnt, next_cnt;      // clocks to next beat
   logic [1:0]                beat_n, next_beat_n;
   logic                      mis, next_mis;      // quad-word misaligned
   logic [ADDR_W-1:ROW_LSB]   page, next_page;    // open page
   logic                      page_ok, next_page_ok;
   logic                      address_acknowledge_n_n, next_address_acknowledge_n_n;
   logic                      beat, next_beat;
   logic                      blk, next_blk;
   logic                      flb, next_flb;
   logic [63:0]               rdat, next_rdat;
   logic                      e1, next_e1;
   logic                      e2, next_e2;
   logic                      bsy, next_bsy;      // access in flight
   logic                      start;
   logic                      hit;
   logic [7:0]                syn;
   logic [71:0]               fixw;

   assign start = !transfer_start_strobe_n_i;
   assign hit   = page_ok && (addr_i[ADDR_W-1:ROW_LSB] == page);
   assign syn   = pml_syn(rd_word_i);

   // flip the single bad bit; a double error is flagged, not fixed
   always_comb
   begin
      fixw = rd_word_i;
      if (syn[7] && syn[6:0] < 7'd72)
         fixw[syn[6:0]] = ~rd_word_i[syn[6:0]];
   end

   // sequencing: counts down clocks before each beat
   always_comb
   begin
      next_state   = state;
      next_kind    = kind;
      next_prev    = prev;
      next_tgt     = tgt;
      next_cnt     = cnt;
      next_beat_n  = beat_n;
      next_mis     = mis;
      next_page    = page;
      next_page_ok = page_ok;
      next_address_acknowledge_n_n  = 1'b1;
      next_beat    = 1'b0;
      next_blk     = blk;
      next_flb     = flb;
      next_rdat    = rdat;
      next_e1      = 1'b0;
      next_e2      = 1'b0;
      case (state)
         PML_S_IDLE:
            if (start)
            begin
               // a start is taken only here in idle; a start while busy is ignored
               next_kind   = burst_i ? (write_i ? PML_BWR : PML_BRD)
                                     : (write_i ? PML_SWR : PML_SRD);
               next_mis    = burst_i && (addr_i[4:3] != 2'b00);
               next_beat_n = 2'd0;
               next_address_acknowledge_n_n = 1'b0;
               next_state  = PML_S_WAIT;
               if (addr_i >= FLASH_BASE)
               begin
                  // reset vector lands in the strap-chosen bank
                  next_tgt = (addr_i == RESET_VEC)
                             ? (strap_q ? PML_TGT_FLB : PML_TGT_FLA)
                             : (addr_i[22] ? PML_TGT_FLA : PML_TGT_FLB);
                  next_flb = (next_tgt == PML_TGT_FLB);
                  // flash burst read 68 first, byte 20, write 19
                  next_cnt = (write_i ? FL_WR
                             : (one_byte_i && !burst_i) ? FL_BYTE : FL_BEAT1)
                             - 8'h01;
                  // bank a narrow and burst writes are taken: first beat after FL_WR, burst beats FL_BEATN apart
               end
               else
               begin
                  next_tgt     = PML_TGT_DRAM;
                  next_blk     = addr_i[BLK_BIT];
                  // the start edge is the first counted clock
                  next_cnt     = pml_first(edo_q, next_kind, prev,
                                           hit, next_mis) - 8'h01;
                  next_prev    = next_kind;
                  next_page    = addr_i[ADDR_W-1:ROW_LSB];
                  next_page_ok = 1'b1;
               end
            end
            else
               next_prev = PML_IDLE;  // idle gap ends back-to-back
         PML_S_WAIT:
            if (cnt <= 8'h01)
            begin
               next_beat = 1'b1;
               // read kind comes from the latched access, not the pin
               if (kind == PML_BRD || kind == PML_SRD)
               begin
                  next_rdat = fixw[63:0];
                  next_e1   = (tgt == PML_TGT_DRAM) && syn[7];
                  next_e2   = (tgt == PML_TGT_DRAM) && !syn[7]
                              && (syn[6:0] != 7'h00);
               end
               if ((kind != PML_BRD && kind != PML_BWR) || beat_n == 2'd3)
                  next_state = PML_S_IDLE;   // last beat frees the bus
               else
               begin
                  // reload on the beat edge itself so a gap of one works
                  next_beat_n = beat_n + 2'd1;
                  if (tgt != PML_TGT_DRAM)
                     next_cnt = FL_BEATN;
                  else if (kind == PML_BWR)
                     next_cnt = 8'h01;
                  else
                     next_cnt = pml_gap(edo_q, mis, beat_n + 2'd1);
               end
            end
            else
               next_cnt = cnt - 8'h01;
         default:
            next_state = PML_S_IDLE;
      endcase
      // busy leaves with the last beat so a pipelined start is taken next
      next_bsy = (next_state != PML_S_IDLE);
   end

   // state registers
   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state   <= PML_S_IDLE;
         kind    <= PML_IDLE;
         prev    <= PML_IDLE;
         tgt     <= PML_TGT_DRAM;
         cnt     <= 8'h00;
         beat_n  <= 2'd0;
         mis     <= 1'b0;
         page    <= '0;
         page_ok <= 1'b0;
         address_acknowledge_n_n  <= 1'b1;
         beat    <= 1'b0;
         blk     <= 1'b0;
         flb     <= 1'b0;
         rdat    <= 64'h0;
         e1      <= 1'b0;
         e2      <= 1'b0;
         bsy     <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         kind    <= next_kind;
         prev    <= next_prev;
         tgt     <= next_tgt;
         cnt     <= next_cnt;
         beat_n  <= next_beat_n;
         mis     <= next_mis;
         page    <= next_page;
         page_ok <= next_page_ok;
         address_acknowledge_n_n  <= next_address_acknowledge_n_n;
         beat    <= next_beat;
         blk     <= next_blk;
         flb     <= next_flb;
         rdat    <= next_rdat;
         e1      <= next_e1;
         e2      <= next_e2;
         bsy     <= next_bsy;
      end
   end

   assign address_acknowledge_n_o = address_acknowledge_n_n;
   assign beat_o       = beat;
   assign rd_data_o    = rdat;
   assign ecc_single_o = e1;
   assign ecc_double_o = e2;
   assign block_b_o    = blk;
   assign flash_b_o    = flb;
   assign busy_o       = bsy;

   // counts are exact here and in the bench checks
   chk_beat_after_wait: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      (state == PML_S_WAIT && cnt <= 8'h01) |=> beat)
      else $error("beat missing after count expiry");
   chk_ack_on_start: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      (state == PML_S_IDLE && start) |=> !address_acknowledge_n_n)
      else $error("no address acknowledge");
   chk_vec_bank: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      (state == PML_S_IDLE && start && addr_i == RESET_VEC)
      |=> (flb == strap_q))
      else $error("reset vector bank wrong");
   chk_flash_first: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      (state == PML_S_IDLE && start && addr_i >= FLASH_BASE
       && !write_i && !one_byte_i) |=> (cnt == FL_BEAT1 - 8'h01))
      else $error("flash first beat count");
   chk_flash_wr: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      (state == PML_S_IDLE && start && addr_i >= FLASH_BASE && write_i)
      |=> (cnt == FL_WR - 8'h01))
      else $error("flash write count");
   chk_idle_edo_rd: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      (state == PML_S_IDLE && start && addr_i < FLASH_BASE && edo_q
       && !write_i && prev == PML_IDLE) |=> (cnt == ED_BRD_IDLE - 8'h01))
      else $error("edo idle read count");
   chk_idle_fp_wr: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      (state == PML_S_IDLE && start && addr_i < FLASH_BASE && !edo_q
       && write_i && prev == PML_IDLE) |=> (cnt == FP_BWR_IDLE - 8'h01))
      else $error("fast-page idle write count");
   chk_ecc_excl: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      !(e1 && e2))
      else $error("both ecc flags set");
   chk_blk_sel: assert property (@(posedge mclk_i)
      disable iff (!rst_n_i)
      (state == PML_S_IDLE && start && addr_i < FLASH_BASE)
      |=> (blk == $past(addr_i[BLK_BIT])))
      else $error("interleave block wrong");
   cov_burst: cover property (@(posedge mclk_i) beat && beat_n == 2'd3);
   cov_hit: cover property (@(posedge mclk_i)
      state == PML_S_IDLE && start && hit);
   cov_flash: cover property (@(posedge mclk_i) beat && tgt != PML_TGT_DRAM);
endmodule

/* core/pml_pkg.sv */
// package for the processor-bus memory latency controller
package pml_pkg;
   // access kinds seen on the bus and remembered for back-to-back choice
   typedef enum logic [2:0] {
      PML_IDLE,
      PML_BRD,
      PML_BWR,
      PML_SRD,
      PML_SWR
   } pml_kind_t;

   // target region of an access
   typedef enum logic [1:0] {
      PML_TGT_DRAM,
      PML_TGT_FLA,
      PML_TGT_FLB
   } pml_tgt_t;

   localparam int ADDR_W      = 36;
   localparam int ROW_LSB     = 12;
   localparam int BLK_BIT     = 5;
   localparam logic [35:0] RESET_VEC = 36'hFFFF00100;
   localparam logic [35:0] FLASH_BASE = 36'hFFF000000;
   localparam logic        STRAP_RST = 1'b1;  // bank b by default

   // first-beat counts, fast-page parts: idle, miss, hit
   localparam logic [7:0] FP_BRD_IDLE  = 8'h09;
   localparam logic [7:0] FP_BRD_MISS  = 8'h07;
   localparam logic [7:0] FP_BRD_HIT   = 8'h03;
   localparam logic [7:0] FP_BRDM_MISS = 8'h06;
   localparam logic [7:0] FP_BRDM_HIT  = 8'h02;
   localparam logic [7:0] FP_BWR_IDLE  = 8'h04;
   localparam logic [7:0] FP_BWR_MISS  = 8'h07;
   localparam logic [7:0] FP_BWR_HIT   = 8'h03;
   localparam logic [7:0] FP_SRD_IDLE  = 8'h09;
   localparam logic [7:0] FP_SRD_MISS  = 8'h08;
   localparam logic [7:0] FP_SRD_HIT   = 8'h06;
   localparam logic [7:0] FP_SWR_IDLE  = 8'h04;
   localparam logic [7:0] FP_SWR_MISS  = 8'h0C;
   localparam logic [7:0] FP_SWR_HIT   = 8'h0A;
   // first-beat counts, edo parts
   localparam logic [7:0] ED_BRD_IDLE  = 8'h08;
   localparam logic [7:0] ED_BRD_MISS  = 8'h05;
   localparam logic [7:0] ED_BRD_HIT   = 8'h02;
   localparam logic [7:0] ED_BRDM_MISS = 8'h04;
   localparam logic [7:0] ED_BRDM_HIT  = 8'h02;
   localparam logic [7:0] ED_BWR_IDLE  = 8'h04;
   localparam logic [7:0] ED_BWR_MISS  = 8'h04;
   localparam logic [7:0] ED_BWR_HIT   = 8'h03;
   localparam logic [7:0] ED_SRD_IDLE  = 8'h08;
   localparam logic [7:0] ED_SRD_MISS  = 8'h07;
   localparam logic [7:0] ED_SRD_HIT   = 8'h05;
   localparam logic [7:0] ED_SWR_IDLE  = 8'h04;
   localparam logic [7:0] ED_SWR_MISS  = 8'h09;
   localparam logic [7:0] ED_SWR_HIT   = 8'h07;
   // flash port counts
   localparam logic [7:0] FL_BEAT1     = 8'h44;
   localparam logic [7:0] FL_BEATN     = 8'h40;
   localparam logic [7:0] FL_BYTE      = 8'h14;
   localparam logic [7:0] FL_WR        = 8'h13;
endpackage

/* tb/pml_bus_master.sv */
// bus master model: issues pipelined accesses and times the beats
`timescale 1ns/1ps
module pml_bus_master
(
   input  wire logic        mclk_i,
   input  wire logic        busy_i,
   input  wire logic        address_acknowledge_n_n_i,
   input  wire logic        beat_i,
   input  wire logic [63:0] rd_data_i,
   input  wire logic [3:0]  flags_i,
   output logic             strobe_n_o,
   output logic [35:0]      addr_o,
   output logic             write_o,
   output logic             burst_o,
   output logic             byte_o
);
   int          first;    // start edge to first beat
   int          gap [3];  // spacing of later beats
   int          ack_at;   // start edge to address acknowledge
   int          n_ack;    // acknowledges seen in one access
   logic [63:0] data;     // read data at first beat
   logic [3:0]  flags;    // ecc single, ecc double, block, flash bank

   // idle bus at time zero
   initial
   begin
      strobe_n_o = 1'b1;
      addr_o = 36'h000000000;
      write_o = 1'b0;
      burst_o = 1'b0;
      byte_o = 1'b0;
   end

   // one access; poke fires a start while busy, which must be ignored
   task automatic access(input int idle, input logic wr, input logic bu,
                         input logic by, input logic [35:0] a,
                         input int poke);
      int k;
      int last;
      int nb;
      k = 0;
      last = 0;
      nb = 0;
      n_ack = 0;
      first = -1;
      ack_at = -1;
      gap = '{-1, -1, -1};
      repeat (idle) @(negedge mclk_i);
      // earliest start once the previous access lets go of busy
      while (busy_i !== 1'b0) @(negedge mclk_i);
      strobe_n_o = 1'b0;
      addr_o = a;
      write_o = wr;
      burst_o = bu;
      byte_o = by;
      @(posedge mclk_i);
      while (nb < (bu ? 4 : 1) && k < 400)
      begin
         @(negedge mclk_i);
         k++;
         if (k == 2)
         begin
            // held through the acknowledge edge, then flipped so that a
            // stale value is never read as valid
            strobe_n_o = 1'b1;
            addr_o = ~addr_o;
            write_o = ~write_o;
            burst_o = ~burst_o;
         end
         if (poke > 2 && k == poke)
            strobe_n_o = 1'b0;
         if (poke > 2 && k == poke + 1)
            strobe_n_o = 1'b1;
         if (address_acknowledge_n_n_i === 1'b0)
         begin
            n_ack++;
            if (ack_at < 0)
               ack_at = k;
         end
         if (beat_i === 1'b1)
         begin
            if (nb == 0)
            begin
               first = k;
               data = rd_data_i;
               flags = flags_i;
            end
            else
               gap[nb-1] = k - last;
            last = k;
            nb++;
         end
      end
   endtask
endmodule

/* tb/tb.sv */
// self-checking bench for the memory latency controller
`timescale 1ns/1ps
module tb;
   import pml_pkg::*;
   typedef struct {
      logic e; logic w; logic b; logic p;
      logic [35:0] a; logic [7:0] f; logic [11:0] g;
   } pml_row_t;
   pml_row_t    rows [$];   // ordinary cases, one per access
   logic        mclk;       // bus clock
   logic        rst_n;      // async reset, active low
   logic        strobe_n;   // start strobe from master
   logic [35:0] addr;       // access address
   logic        wr;         // write access
   logic        burst;      // four-beat access
   logic        one_byte;   // single-byte read
   logic        edo;        // edo timing select
   logic        strap;      // boot bank strap
   logic [71:0] rd_word;    // memory word with check bits
   logic        address_acknowledge_n_n;     // address acknowledge
   logic        beat;       // data beat
   logic [63:0] rd_data;    // corrected data
   wire [3:0]   flags;      // ecc single, double, block, flash bank
   logic        busy;       // access in progress
   int          mismatches;
   int          compares;

   pml_ctrl i_dut (.mclk_i(mclk), .rst_n_i(rst_n),
      .transfer_start_strobe_n_i(strobe_n), .addr_i(addr), .write_i(wr),
      .burst_i(burst), .one_byte_i(one_byte), .edo_mode_i(edo),
      .boot_bank_strap_i(strap), .rd_word_i(rd_word),
      .address_acknowledge_n_o(address_acknowledge_n_n), .beat_o(beat), .rd_data_o(rd_data),
      .ecc_single_o(flags[3]), .ecc_double_o(flags[2]),
      .block_b_o(flags[1]), .flash_b_o(flags[0]), .busy_o(busy));
   pml_bus_master i_mst (.mclk_i(mclk), .busy_i(busy), .address_acknowledge_n_n_i(address_acknowledge_n_n),
      .beat_i(beat), .rd_data_i(rd_data), .flags_i(flags),
      .strobe_n_o(strobe_n), .addr_o(addr), .write_o(wr),
      .burst_o(burst), .byte_o(one_byte));

   // 100 mhz clock
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   task automatic chk_cnt(input string n, input int e, input int g);
      compares++;
      if (e != g)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
      end
   endtask

   task automatic chk_val(input string n, input logic [63:0] e,
                          input logic [63:0] g);
      compares++;
      if (e !== g)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic final_report();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic add(input logic e, input logic w, input logic b,
                      input logic p, input logic [35:0] a,
                      input logic [7:0] f, input logic [11:0] g);
      pml_row_t r;
      r = '{e, w, b, p, a, f, g};
      rows.push_back(r);
   endtask

   // one access and its timing checks; idle gap 0 means back-to-back
   task automatic run(input int idle, input logic w, input logic b,
                      input logic by, input logic [35:0] a, input int f);
      i_mst.access(idle, w, b, by, a, 0);
      chk_cnt("first beat", f, i_mst.first);
      chk_cnt("ack delay", 1, i_mst.ack_at);
   endtask

   // hang guard, far beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge mclk);
      mismatches++;
      final_report();
   end

   initial
   begin
      mismatches = 0;
      compares = 0;
      rst_n = 1'b0;
      edo = 1'b0;
      strap = 1'b1;
      rd_word = 72'h000000000000000000;
      // fast-page rows
      add(0, 0, 1, 0, 36'h000001000, 8'h09, 12'h121);
      add(0, 0, 1, 1, 36'h000001040, 8'h03, 12'h121);
      add(0, 0, 1, 1, 36'h000002020, 8'h07, 12'h121);
      add(0, 0, 1, 1, 36'h000002008, 8'h02, 12'h311);
      add(0, 0, 1, 1, 36'h000003008, 8'h06, 12'h311);
      add(0, 0, 1, 0, 36'h000003038, 8'h09, 12'h311);
      add(0, 1, 1, 0, 36'h000004000, 8'h04, 12'h111);
      add(0, 1, 1, 1, 36'h000004020, 8'h03, 12'h111);
      add(0, 1, 1, 1, 36'h000005000, 8'h07, 12'h111);
      add(0, 0, 0, 0, 36'h000006000, 8'h09, 12'h000);
      add(0, 0, 0, 1, 36'h000006028, 8'h06, 12'h000);
      add(0, 0, 0, 1, 36'h000007000, 8'h08, 12'h000);
      add(0, 1, 0, 0, 36'h000008000, 8'h04, 12'h000);
      add(0, 1, 0, 1, 36'h000008030, 8'h0A, 12'h000);
      add(0, 1, 0, 1, 36'h000009000, 8'h0C, 12'h000);
      // edo rows
      add(1, 0, 1, 0, 36'h000001000, 8'h08, 12'h111);
      add(1, 0, 1, 1, 36'h000001040, 8'h02, 12'h111);
      add(1, 0, 1, 1, 36'h000002020, 8'h05, 12'h111);
      add(1, 0, 1, 1, 36'h000002008, 8'h02, 12'h211);
      add(1, 0, 1, 1, 36'h000003008, 8'h04, 12'h211);
      add(1, 0, 1, 0, 36'h000003038, 8'h08, 12'h211);
      add(1, 1, 1, 0, 36'h000004000, 8'h04, 12'h111);
      add(1, 1, 1, 1, 36'h000004020, 8'h03, 12'h111);
      add(1, 1, 1, 1, 36'h000005000, 8'h04, 12'h111);
      add(1, 0, 0, 0, 36'h000006000, 8'h08, 12'h000);
      add(1, 0, 0, 1, 36'h000006028, 8'h05, 12'h000);
      add(1, 0, 0, 1, 36'h000007000, 8'h07, 12'h000);
      add(1, 1, 0, 0, 36'h000008000, 8'h04, 12'h000);
      add(1, 1, 0, 1, 36'h000008030, 8'h07, 12'h000);
      add(1, 1, 0, 1, 36'h000009000, 8'h09, 12'h000);
      repeat (6) @(negedge mclk);
      // outputs stand quiet while reset is held
      chk_val("address_acknowledge_n in reset", 64'h1, 64'(address_acknowledge_n_n));
      chk_val("beat in reset", 64'h0, 64'(beat));
      chk_val("busy in reset", 64'h0, 64'(busy));
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      $display("reset test done");
      foreach (rows[i])
      begin
         if (rows[i].e !== edo)
         begin
            edo = rows[i].e;
            repeat (5) @(negedge mclk);
         end
         run(rows[i].p ? 0 : 3, rows[i].w, rows[i].b, 1'b0, rows[i].a,
             int'(rows[i].f));
         chk_val("block", 64'(rows[i].a[5]), 64'(i_mst.flags[1]));
         if (rows[i].b)
            for (int j = 0; j < 3; j++)
               chk_cnt("beat gap", int'(rows[i].g[8-4*j +: 4]),
                       i_mst.gap[j]);
         if (!rows[i].w)
            chk_val("read data", 64'h0, i_mst.data);
         $display("row %0d done", i);
      end
      // single flipped bit corrected, two flipped bits flagged
      rd_word = 72'h000000000000000001;
      run(3, 1'b0, 1'b0, 1'b0, 36'h000006000, 8);
      chk_val("corrected data", 64'h0, i_mst.data);
      chk_val("single flag", 64'h1, 64'(i_mst.flags[3]));
      rd_word = 72'h000000000000000003;
      run(3, 1'b0, 1'b0, 1'b0, 36'h000006000, 8);
      chk_val("double flag", 64'h1, 64'(i_mst.flags[2]));
      rd_word = 72'h000000000000000000;
      $display("ecc test done");
      // start strobe during busy is ignored
      i_mst.access(3, 1'b0, 1'b1, 1'b0, 36'h000001000, 3);
      chk_cnt("acks per access", 1, i_mst.n_ack);
      chk_cnt("first beat", 8, i_mst.first);
      $display("refusal test done");
      // boot vector follows the strap, bank b by default
      run(3, 1'b0, 1'b0, 1'b0, RESET_VEC, 68);
      chk_val("boot bank", 64'h1, 64'(i_mst.flags[0]));
      @(negedge mclk);
      strap = 1'b0;
      repeat (5) @(negedge mclk);
      run(3, 1'b0, 1'b0, 1'b0, RESET_VEC, 68);
      chk_val("boot bank", 64'h0, 64'(i_mst.flags[0]));
      run(3, 1'b0, 1'b0, 1'b1, FLASH_BASE, 20);
      chk_val("flash bank", 64'h1, 64'(i_mst.flags[0]));
      run(3, 1'b0, 1'b1, 1'b0, FLASH_BASE, 68);
      for (int j = 0; j < 3; j++)
         chk_cnt("flash gap", 64, i_mst.gap[j]);
      // bank a is written full width here, as a program sequence step
      run(3, 1'b1, 1'b0, 1'b0, 36'hFFF400000, 19);
      chk_val("flash bank", 64'h0, 64'(i_mst.flags[0]));
      $display("flash test done");
      final_report();
   end
endmodule
